// ### hdl/phy_port_control_consts.vh
// Offsets, field positions, reset values and timing counts of the PHY port control registers
`ifndef PHY_PORT_CONTROL_CONSTS_VH
`define PHY_PORT_CONTROL_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PORT1_CTRL_A_OFFSET 8'h1c
`define PORT2_CTRL_A_OFFSET 8'h2c
`define PORT3_CTRL_A_OFFSET 8'h3c
`define PORT1_CTRL_B_OFFSET 8'h1d
`define PORT2_CTRL_B_OFFSET 8'h2d
`define PORT3_CTRL_B_OFFSET 8'h3d

// ----------------------------------------
// Control A fields
// ----------------------------------------
`define CA_NEG_ENABLE 7
`define CA_FORCE_SPEED 6
`define CA_FORCE_DUPLEX 5
`define CA_ADV_PAUSE 4
`define CA_ADV_100FD 3
`define CA_ADV_100HD 2
`define CA_ADV_10FD 1
`define CA_ADV_10HD 0
`define CA_ADV_RESET 5'h1f

// ----------------------------------------
// Control B fields
// ----------------------------------------
`define CB_LED_OFF 7
`define CB_TX_DISABLE 6
`define CB_RESTART_NEG 5
`define CB_FAR_FAULT_OFF 4
`define CB_POWER_DOWN 3
`define CB_XOVER_OFF 2
`define CB_FORCE_MDI 1
`define CB_RESET 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define RESTART_PULSE_CYCLES 4'h1

`endif

// ### hdl/phy_port_slice.v
// Control registers and PHY control outputs of one copper port
`timescale 1ns/1ps
`include "phy_port_control_consts.vh"

module phy_port_slice (
	// System
	input wire clock,
	input wire reset_n,
	// Register access
	input wire writeA,
	input wire writeB,
	input wire [7:0] writeData,
	// Straps, already synchronised
	input wire strapCapture,
	input wire strapNegEnable,
	input wire strapSpeed,
	input wire strapDuplex,
	// PHY status
	input wire negDone,
	input wire [1:0] rawIndicator,
	// Register contents
	output wire [7:0] controlA,
	output wire [7:0] controlB,
	// PHY control
	output reg negEnable,
	output reg speed100,
	output reg fullDuplex,
	output reg [4:0] advertise,
	output reg restartNeg,
	output reg txDisable,
	output reg farFaultOff,
	output reg powerDown,
	output reg autoCrossover,
	output reg mdiMode,
	output reg portIndicatorHi,
	output reg portIndicatorLo
);

	reg [7:0] regA;
	reg [7:0] regB;

	assign controlA = regA;
	// Restart reads back the moment it is written; it is cleared on the next edge without a control B write
	assign controlB = regB;

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			regA <= {3'h7, `CA_ADV_RESET};
			regB <= `CB_RESET;
		end else begin
			if (strapCapture) begin
				regA[`CA_NEG_ENABLE] <= strapNegEnable;
				regA[`CA_FORCE_SPEED] <= strapSpeed;
				regA[`CA_FORCE_DUPLEX] <= strapDuplex;
			end else if (writeA) begin
				regA <= writeData;
			end
			if (writeB) begin
				regB <= writeData;
			end else begin
				// Self-clearing for readback only; restartNeg pulses on every write of 1 whatever this bit holds
				regB[`CB_RESTART_NEG] <= 1'b0;
			end
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			negEnable <= 1'b1;
			speed100 <= 1'b1;
			fullDuplex <= 1'b1;
			advertise <= `CA_ADV_RESET;
			restartNeg <= 1'b0;
			txDisable <= 1'b0;
			farFaultOff <= 1'b0;
			powerDown <= 1'b0;
			autoCrossover <= 1'b1;
			mdiMode <= 1'b0;
			portIndicatorHi <= 1'b1;
			portIndicatorLo <= 1'b1;
		end else begin
			negEnable <= regA[`CA_NEG_ENABLE];
			speed100 <= regA[`CA_FORCE_SPEED];
			// Forced duplex governs unless negotiation is on and has finished
			if (!regA[`CA_NEG_ENABLE] || !negDone) begin
				fullDuplex <= regA[`CA_FORCE_DUPLEX];
			end else begin
				fullDuplex <= regA[`CA_ADV_100FD] | regA[`CA_ADV_10FD];
			end
			advertise[4] <= regA[`CA_ADV_PAUSE];
			advertise[3] <= regA[`CA_ADV_100FD];
			advertise[2] <= regA[`CA_ADV_100HD];
			advertise[1] <= regA[`CA_ADV_10FD];
			advertise[0] <= regA[`CA_ADV_10HD];
			restartNeg <= writeB & writeData[`CB_RESTART_NEG];
			txDisable <= regB[`CB_TX_DISABLE];
			farFaultOff <= regB[`CB_FAR_FAULT_OFF];
			powerDown <= regB[`CB_POWER_DOWN];
			autoCrossover <= ~regB[`CB_XOVER_OFF];
			mdiMode <= regB[`CB_XOVER_OFF] & regB[`CB_FORCE_MDI];
			portIndicatorHi <= regB[`CB_LED_OFF] | rawIndicator[1];
			portIndicatorLo <= regB[`CB_LED_OFF] | rawIndicator[0];
		end
	end

endmodule

// ### hdl/phy_port_control_regs.v
// Control register bank for the two copper PHY ports of the switch
`timescale 1ns/1ps
`include "phy_port_control_consts.vh"


module phy_port_control_regs (
	// System
	input wire clock,
	input wire reset_n,
	// Register port from the management interface
	input wire [7:0] regAddr,
	input wire regWrite,
	input wire [7:0] regWriteData,
	// Read data, one edge behind regAddr
	output reg [7:0] regReadData,
	// Strap pins of port 1, asynchronous
	input wire portOneNegStrap,
	input wire portOneSpeedStrap,
	input wire portOneDuplexStrap,
	// Strap pins of port 2, asynchronous
	input wire portTwoNegStrap,
	input wire portTwoSpeedStrap,
	input wire portTwoDuplexStrap,
	// PHY status, same clock
	input wire [1:0] negDone,
	input wire [3:0] rawIndicator,
	// PHY control, index 0 is port 1
	output wire [1:0] negEnable,
	output wire [1:0] speed100,
	output wire [1:0] fullDuplex,
	output wire [9:0] advertise,
	// Line control
	output wire [1:0] restartNeg,
	output wire [1:0] txDisable,
	output wire [1:0] farFaultOff,
	output wire [1:0] powerDown,
	output wire [1:0] autoCrossover,
	output wire [1:0] mdiMode,
	// Indicators, high is dark
	output wire [1:0] portIndicatorHi,
	output wire [1:0] portIndicatorLo
);

	// ----------------------------------------
	// Strap capture
	// ----------------------------------------
	// Straps pass two flops; the second stage is loaded into the
	// registers once both stages hold pin levels, three edges after release.
	wire [5:0] strapPins;
	reg [5:0] strapMeta;
	reg [5:0] strapSync;
	reg [1:0] captureDelay;
	wire strapCapture;

	assign strapPins = {portTwoDuplexStrap, portTwoSpeedStrap, portTwoNegStrap,
		portOneDuplexStrap, portOneSpeedStrap, portOneNegStrap};

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			strapMeta <= 6'h00;
			strapSync <= 6'h00;
		end else begin
			strapMeta <= strapPins;
			strapSync <= strapMeta;
		end
	end

	// Waits out both synchroniser stages, then parks
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			captureDelay <= 2'h0;
		end else if (captureDelay != 2'h3) begin
			captureDelay <= captureDelay + 2'h1;
		end
	end

	// A control A write on the capture edge is lost to the straps
	assign strapCapture = (captureDelay == 2'h2);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// One-hot select shared by the write strobes and the read path.
	// Third port locations match nothing: writes dropped, reads zero.
	function [3:0] selectReg;
		input [7:0] addr;
		begin
			case (addr)
				`PORT1_CTRL_A_OFFSET: selectReg = 4'h1;
				`PORT2_CTRL_A_OFFSET: selectReg = 4'h2;
				`PORT1_CTRL_B_OFFSET: selectReg = 4'h4;
				`PORT2_CTRL_B_OFFSET: selectReg = 4'h8;
				default: selectReg = 4'h0;
			endcase
		end
	endfunction

	wire [3:0] regSelect;
	wire [7:0] ctrlA1;
	wire [7:0] ctrlA2;
	wire [7:0] ctrlB1;
	wire [7:0] ctrlB2;
	wire wrA1;
	wire wrA2;
	wire wrB1;
	wire wrB2;
	reg [7:0] readMux;

	assign regSelect = selectReg(regAddr);
	assign wrA1 = regWrite & regSelect[0];
	assign wrA2 = regWrite & regSelect[1];
	assign wrB1 = regWrite & regSelect[2];
	assign wrB2 = regWrite & regSelect[3];

	always @* begin
		case (regSelect)
			4'h1: readMux = ctrlA1;
			4'h2: readMux = ctrlA2;
			4'h4: readMux = ctrlB1;
			4'h8: readMux = ctrlB2;
			default: readMux = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Registered so the port never shows decode glitches; a value
	// written on one edge is read back from the following edge.
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			regReadData <= 8'h00;
		end else begin
			regReadData <= readMux;
		end
	end

	// ----------------------------------------
	// Port 1 slice
	// ----------------------------------------
	phy_port_slice portOne (
		.clock(clock),
		.reset_n(reset_n),
		.writeA(wrA1),
		.writeB(wrB1),
		.writeData(regWriteData),
		.strapCapture(strapCapture),
		.strapNegEnable(strapSync[0]),
		.strapSpeed(strapSync[1]),
		.strapDuplex(strapSync[2]),
		.negDone(negDone[0]),
		.rawIndicator(rawIndicator[1:0]),
		.controlA(ctrlA1),
		.controlB(ctrlB1),
		.negEnable(negEnable[0]),
		.speed100(speed100[0]),
		.fullDuplex(fullDuplex[0]),
		.advertise(advertise[4:0]),
		.restartNeg(restartNeg[0]),
		.txDisable(txDisable[0]),
		.farFaultOff(farFaultOff[0]),
		.powerDown(powerDown[0]),
		.autoCrossover(autoCrossover[0]),
		.mdiMode(mdiMode[0]),
		.portIndicatorHi(portIndicatorHi[0]),
		.portIndicatorLo(portIndicatorLo[0])
	);

	// ----------------------------------------
	// Port 2 slice
	// ----------------------------------------
	phy_port_slice portTwo (
		.clock(clock),
		.reset_n(reset_n),
		.writeA(wrA2),
		.writeB(wrB2),
		.writeData(regWriteData),
		.strapCapture(strapCapture),
		.strapNegEnable(strapSync[3]),
		.strapSpeed(strapSync[4]),
		.strapDuplex(strapSync[5]),
		.negDone(negDone[1]),
		.rawIndicator(rawIndicator[3:2]),
		.controlA(ctrlA2),
		.controlB(ctrlB2),
		.negEnable(negEnable[1]),
		.speed100(speed100[1]),
		.fullDuplex(fullDuplex[1]),
		.advertise(advertise[9:5]),
		.restartNeg(restartNeg[1]),
		.txDisable(txDisable[1]),
		.farFaultOff(farFaultOff[1]),
		.powerDown(powerDown[1]),
		.autoCrossover(autoCrossover[1]),
		.mdiMode(mdiMode[1]),
		.portIndicatorHi(portIndicatorHi[1]),
		.portIndicatorLo(portIndicatorLo[1])
	);

endmodule

// ### bench/phy_port_control_assertions.sv
// Concurrent checks on the PHY port control register bank
`timescale 1ns/1ps
module phy_port_control_checker (
	// System
	input wire clock,
	input wire reset_n,
	// Register port
	input wire [7:0] regAddr,
	input wire regWrite,
	input wire [7:0] regWriteData,
	input wire [7:0] regReadData,
	// PHY side
	input wire [3:0] rawIndicator,
	input wire [1:0] negEnable,
	input wire [1:0] speed100,
	input wire [1:0] fullDuplex,
	input wire [9:0] advertise,
	input wire [1:0] restartNeg,
	input wire [1:0] txDisable,
	input wire [1:0] powerDown,
	input wire [1:0] autoCrossover,
	input wire [1:0] mdiMode,
	input wire [1:0] portIndicatorHi
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	wire wrA = regWrite && regAddr == 8'h1c;
	wire wrB = regWrite && regAddr == 8'h1d;
	wire kick = wrB && regWriteData[5];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	adv_one_a: assert property (wrA |-> ##2 advertise[4:0] == $past(regWriteData[4:0], 2))
		else $error("port one advertisement wrong");
	adv_two_a: assert property (regWrite && regAddr == 8'h2c |-> ##2
		advertise[9:5] == $past(regWriteData[4:0], 2)) else $error("port two advertisement wrong");
	force_mode_a: assert property (wrA |-> ##2 negEnable[0] == $past(regWriteData[7], 2) &&
		speed100[0] == $past(regWriteData[6], 2)) else $error("forced mode wrong");
	force_duplex_a: assert property (wrA && !regWriteData[7] |-> ##2
		fullDuplex[0] == $past(regWriteData[5], 2)) else $error("forced duplex wrong");
	restart_pulse_a: assert property (kick |=> restartNeg[0])
		else $error("restart missing");
	restart_only_a: assert property (!kick |=> !restartNeg[0])
		else $error("restart without write");
	tx_power_a: assert property (wrB |-> ##2 txDisable[0] == $past(regWriteData[6], 2) &&
		powerDown[0] == $past(regWriteData[3], 2)) else $error("tx or power control wrong");
	mdi_cross_a: assert property (mdiMode[0] |-> !autoCrossover[0])
		else $error("forced mode with crossover on");
	led_raw_a: assert property (!portIndicatorHi[0] |-> !$past(rawIndicator[1]))
		else $error("indicator low while off");
	reserved_read_a: assert property (regAddr == 8'h3d |=> regReadData == 8'h00)
		else $error("reserved location not zero");
	led_blank_a: assert property (wrB && regWriteData[7] |-> ##2 portIndicatorHi[0])
		else $error("indicator not blanked");
	restart_c: cover property (kick ##1 restartNeg[0]);
	led_off_c: cover property (wrB && regWriteData[7]);
	mdi_c: cover property (mdiMode[0]);
endmodule

bind phy_port_control_regs phy_port_control_checker chk (.clock, .reset_n, .regAddr, .regWrite,
	.regWriteData, .regReadData, .rawIndicator, .negEnable, .speed100, .fullDuplex, .advertise,
	.restartNeg, .txDisable, .powerDown, .autoCrossover, .mdiMode, .portIndicatorHi);

// ### bench/phy_link_partner.sv
// Behavioural stand-in for the PHY and cable partner behind the port controls
`timescale 1ns/1ps
module phy_link_partner (
	// System
	input wire clock,
	input wire reset_n,
	// Controls from the bank
	input wire [1:0] restartNeg,
	// Status to the bank
	output reg [1:0] negDone,
	output reg [3:0] rawIndicator
);
	reg [2:0] settle;

	// ----------------------------------------
	// Negotiation and indicators
	// ----------------------------------------
	// A restart drops the result and flips the port's raw indicators,
	// so blanking can be told apart from a raw high level
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			negDone <= 2'h0;
			rawIndicator <= 4'h5;
			settle <= 3'h4;
		end else if (|restartNeg) begin
			negDone <= negDone & ~restartNeg;
			rawIndicator <= rawIndicator ^ {{2{restartNeg[1]}}, {2{restartNeg[0]}}};
			settle <= 3'h4;
		end else if (settle != 3'h0) begin
			settle <= settle - 3'h1;
		end else begin
			negDone <= 2'h3;
		end
	end
endmodule

// ### bench/phy_port_control_regs_tb_top.sv
// Self-checking bench for the PHY port control register bank
`timescale 1ns/1ps
module phy_port_control_regs_tb_top;
	reg clock = 0;
	reg reset_n = 0;
	reg [7:0] regAddr = 8'h00;
	reg regWrite = 0;
	reg [7:0] regWriteData = 8'h00;
	reg [5:0] strap = 6'h00;
	reg [7:0] ad;
	wire [7:0] regReadData;
	wire [1:0] negDone, negEnable, speed100, fullDuplex, restartNeg, txDisable, farFaultOff;
	wire [1:0] powerDown, autoCrossover, mdiMode, portIndicatorHi, portIndicatorLo;
	wire [3:0] rawIndicator;
	wire [9:0] advertise;
	integer fails = 0;
	integer checkCount = 0;
	integer regA [0:1];
	integer regB [0:1];
	integer i, p, a, b, d;

	always #12.5 clock = ~clock;

	phy_port_control_regs uut (.clock, .reset_n, .regAddr, .regWrite, .regWriteData,
		.regReadData, .portOneNegStrap(strap[0]), .portOneSpeedStrap(strap[1]),
		.portOneDuplexStrap(strap[2]), .portTwoNegStrap(strap[3]), .portTwoSpeedStrap(strap[4]),
		.portTwoDuplexStrap(strap[5]), .negDone, .rawIndicator, .negEnable, .speed100,
		.fullDuplex, .advertise, .restartNeg, .txDisable, .farFaultOff, .powerDown,
		.autoCrossover, .mdiMode, .portIndicatorHi, .portIndicatorLo);
	phy_link_partner partner (.clock, .reset_n, .restartNeg, .negDone, .rawIndicator);

	task check(input [63:0] what, input [9:0] seen, input [9:0] exp);
		begin
			checkCount = checkCount + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("[ERR] %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask

	task wr(input [7:0] adr, input [7:0] dat);
		begin
			@(posedge clock);
			regAddr <= adr;
			regWriteData <= dat;
			regWrite <= 1'b1;
			@(posedge clock);
			regWrite <= 1'b0;
			#1;
		end
	endtask

	task cmpPort(input integer q);
		begin
			a = regA[q];
			b = regB[q];
			check("advert", advertise[5*q +: 5], a[4:0]);
			check("negEn", negEnable[q], a[7]);
			check("speed", speed100[q], a[6]);
			check("duplex", fullDuplex[q], (a[7] && negDone[q]) ? a[3] | a[1] : a[5]);
			check("txDis", txDisable[q], b[6]);
			check("farFault", farFaultOff[q], b[4]);
			check("powerDn", powerDown[q], b[3]);
			check("autoX", autoCrossover[q], !b[2]);
			check("mdi", mdiMode[q], b[2] & b[1]);
			check("ledHi", portIndicatorHi[q], b[7] | rawIndicator[2*q+1]);
			check("ledLo", portIndicatorLo[q], b[7] | rawIndicator[2*q]);
		end
	endtask

	task end_of_test;
		begin
			if (fails == 0 && checkCount > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		d = $urandom(32'hb987);
		@(posedge clock);
		strap <= $urandom & 6'h1b;
		repeat (15) @(posedge clock);
		reset_n <= 1'b1;
		repeat (8) @(posedge clock);
		#1;
		for (p = 0; p < 2; p = p + 1) begin
			regA[p] = {strap[3*p], strap[3*p+1], strap[3*p+2], 5'h1f};
			regB[p] = 0;
			cmpPort(p);
		end
		// Random writes across mapped, reserved and unmapped places
		for (i = 0; i < 80; i = i + 1) begin
			ad = 8'h1b + 8'h10 * ($urandom % 3) + $urandom % 3;
			d = $urandom;
			wr(ad, d[7:0]);
			p = ad[5:4] - 1;
			a = 0;
			if (ad[7:4] < 4'h3 && ad[3:0] == 4'hc) begin
				regA[p] = d[7:0];
				a = d[7:0];
			end
			if (ad[7:4] < 4'h3 && ad[3:0] == 4'hd) begin
				regB[p] = d[7:0] & 8'hdf;
				a = d[7:0];
				check("restart", restartNeg, {1'b0, d[5]} << p);
			end
			@(posedge clock);
			#1;
			check("restEnd", restartNeg, 10'h000);
			check("readback", regReadData, a[7:0]);
			@(posedge clock);
			#1;
			check("selfClr", regReadData, a[7:0] & ((ad[3:0] == 4'hd) ? 8'hdf : 8'hff));
			cmpPort(0);
			cmpPort(1);
			repeat (7) @(posedge clock);
			#1;
			cmpPort(0);
			cmpPort(1);
		end
		end_of_test;
	end

	initial begin
		#100000;
		fails = fails + 1;
		end_of_test;
	end
endmodule
